// >>> logic/ufm_pkg.sv
// Purpose: shared constants of the upset fault monitor suite
// Assumes: 16-bit register words at their printed register addresses
// Notes: field positions and reset values used by monitor and guard
package ufm_pkg;
  localparam logic [15:0] ADDR_PLL_CTL = 16'h01D7;
  localparam logic [15:0] ADDR_STATUS = 16'h01D8;
  localparam logic [15:0] ADDR_TEMP_A = 16'h01E8;
  localparam logic [15:0] ADDR_TEMP_B = 16'h01EA;
  localparam logic [15:0] ADDR_PROT = 16'h01EE;
  // status word
  localparam int PCS_MASK_LSB = 0;
  localparam int PCS_FLAG_LSB = 2;
  localparam int NUM_PCS = 10;
  localparam int ST_CORR = 12;
  localparam int ST_UNCORR = 13;
  localparam int ST_SUM = 14;
  localparam int ST_RESTORE = 15;
  // pll control word
  localparam int PLL_CNT_LSB = 0;
  localparam int PLL_WIN_LSB = 8;
  localparam int PLL_MASK_BIT = 11;
  localparam int PLL_LOCK_BIT = 14;
  localparam int PLL_LOSS_BIT = 15;
  // protection control word
  localparam int PROT_REC_BIT = 0;
  localparam int PROT_STRAP_LSB = 4;
  localparam int PROT_ECC_LSB = 7;
  // temperature words
  localparam int THR_LSB = 0;
  localparam int TEMP_JUMP_BIT = 15;
  // reset values
  localparam logic [15:0] RST_PLL_CTL = 16'h0A10;
  localparam logic [15:0] RST_TEMP_B = 16'h000A;
  localparam logic [15:0] RST_PROT = 16'h0380;
  localparam logic [15:0] RST_STATUS = 16'h0000;
  localparam logic [6:0] PCT_SCALE = 7'h64;
  localparam int NUM_CFG = 3;
  typedef enum logic [0:0] {
    UFM_LOCK = 1'b0,
    UFM_WAIT = 1'b1
  } ufm_lock_t;
endpackage : ufm_pkg

// >>> logic/ufm_cfg_guard.sv
// Purpose: one upset-guarded configuration word
// Assumes: primary copy, shadow copy and parity bit per word
// Notes: a single upset in either copy is corrected, both bad is flagged
`timescale 1ns/1ps
module ufm_cfg_guard #(
  parameter logic [15:0] RST_VAL = 16'h0000
) (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic ecc_en,
  input wire logic wr_en,
  input wire logic [15:0] wdata,
  input wire logic flip,
  output logic [15:0] rdata,
  output logic [15:0] raw,
  output logic corr,
  output logic unc
);
  logic [15:0] prim_r, prim_nxt, copy_r, copy_nxt;
  logic par_r, par_nxt;
  logic prim_ok, copy_ok, differ;

  assign prim_ok = (^prim_r) == par_r;
  assign copy_ok = (^copy_r) == par_r;
  assign differ = prim_r != copy_r;
  assign raw = prim_r;
  assign rdata = (ecc_en && !prim_ok) ? copy_r : prim_r;
  assign corr = ecc_en && differ && (prim_ok || copy_ok);
  assign unc = ecc_en && differ && !prim_ok && !copy_ok;

  always_comb begin
    prim_nxt = prim_r ^ {15'h0000, flip};
    copy_nxt = copy_r;
    par_nxt = par_r;
    if (wr_en) begin
      prim_nxt = wdata;
      copy_nxt = wdata;
      par_nxt = ^wdata;
    end else if (ecc_en && differ) begin
      if (prim_ok) begin
        copy_nxt = prim_r;
      end else if (copy_ok) begin
        prim_nxt = copy_r;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      prim_r <= RST_VAL;
      copy_r <= RST_VAL;
      par_r <= ^RST_VAL;
    end else begin
      prim_r <= prim_nxt;
      copy_r <= copy_nxt;
      par_r <= par_nxt;
    end
  end
endmodule : ufm_cfg_guard

// >>> logic/ufm_monitor.sv
// Purpose: upset fault monitor suite of the phy core
// Assumes: register port already decoded from management access
// Notes: writes are ignored while management lockout is high
// Function
// - illegal pcs transition sets status flag and pcs fault interrupt
// - self-recovery turns a pcs fault into internal reset; interrupt anyway
// - two mask bits in status word suppress pcs fault interrupt
// - ecc detected or corrected change sets config fault status, interrupts
// - three-bit field switches configuration ecc on or off
// - golden checksum taken at reset and lockout rising edge
// - during lockout running sum recomputed; mismatch raises config interrupt
// - lockout falling clears golden sum and stops checking
// - self-recovery on mismatch restores defaults with the current strap_opts inputs
// - temperature step above percentage threshold raises thermal interrupt
// - last temperature reading readable through the temp a register
// - lock drops and interrupts at once when phase leaves window
// - relock after programmed count of reference ticks in window
`timescale 1ns/1ps
module ufm_monitor (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic [15:0] reg_addr,
  input wire logic reg_wr_en,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_rd_en,
  output logic [15:0] reg_rdata,
  input wire logic mgmt_lockout,
  input wire logic [9:0] pcs_bad_trans,
  input wire logic [2:0] cfg_flip,
  input wire logic [2:0] strap_opts,
  input wire logic [9:0] temp_code,
  input wire logic temp_valid,
  input wire logic [2:0] pll_phase_err,
  input wire logic pll_ref_tick,
  output logic pcs_fault_irq_n,
  output logic cfg_upset_irq_n,
  output logic thermal_jump_irq_n,
  output logic upset_event_output_n,
  output logic pll_locked,
  output logic pcs_recover_rst
);
  localparam logic [15:0] CFG_DEF [0:2] = '{ufm_pkg::RST_PLL_CTL,
    ufm_pkg::RST_TEMP_B, ufm_pkg::RST_PROT};

  // guarded words in ascending address order: pll ctl, temp b, prot
  logic [15:0] cfg_val [0:2];
  logic [15:0] cfg_raw [0:2];
  logic [15:0] cfg_wd [0:2];
  logic [2:0] cfg_we, cfg_corr, cfg_unc;
  logic [2:0] ecc_field;
  logic self_rec, ecc_en, restore, wr_ok;

  assign ecc_field = cfg_val[2][ufm_pkg::PROT_ECC_LSB +: 3];
  assign ecc_en = ecc_field != 3'h0;
  assign self_rec = cfg_val[2][ufm_pkg::PROT_REC_BIT];
  assign wr_ok = reg_wr_en && !mgmt_lockout;

  genvar g;
  generate
    for (g = 0; g < ufm_pkg::NUM_CFG; g++) begin : gen_cfg
      ufm_cfg_guard #(
        .RST_VAL(CFG_DEF[g])
      ) u_guard (
        .sys_clk(sys_clk),
        .rst_b(rst_b),
        .ecc_en(ecc_en),
        .wr_en(cfg_we[g]),
        .wdata(cfg_wd[g]),
        .flip(cfg_flip[g]),
        .rdata(cfg_val[g]),
        .raw(cfg_raw[g]),
        .corr(cfg_corr[g]),
        .unc(cfg_unc[g])
      );
    end
  endgenerate

  // checksum group
  logic [1:0] idx_r, idx_nxt;
  logic [15:0] acc_r, acc_nxt, golden_r, golden_nxt, sum;
  logic golden_vld_r, golden_vld_nxt, cap_pend_r, cap_pend_nxt;
  logic lock_d_r, sum_ev;

  always_comb begin
    sum = acc_r + cfg_raw[idx_r];
    idx_nxt = idx_r + 2'h1;
    acc_nxt = sum;
    golden_nxt = golden_r;
    golden_vld_nxt = golden_vld_r;
    cap_pend_nxt = cap_pend_r;
    sum_ev = 1'b0;
    if (idx_r == 2'h2) begin
      idx_nxt = 2'h0;
      acc_nxt = 16'h0000;
      if (cap_pend_r) begin
        golden_nxt = sum;
        golden_vld_nxt = 1'b1;
        cap_pend_nxt = 1'b0;
      end else if (mgmt_lockout && lock_d_r && golden_vld_r &&
                   sum != golden_r) begin
        sum_ev = 1'b1;
      end
    end
    // restart so the captured pass is whole
    if ((mgmt_lockout && !lock_d_r) || restore) begin
      cap_pend_nxt = 1'b1;
      idx_nxt = 2'h0;
      acc_nxt = 16'h0000;
    end
    if (!mgmt_lockout && lock_d_r) begin
      golden_nxt = 16'h0000;
      golden_vld_nxt = 1'b0;
      cap_pend_nxt = 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      idx_r <= 2'h0;
      acc_r <= 16'h0000;
      golden_r <= 16'h0000;
      golden_vld_r <= 1'b0;
      cap_pend_r <= 1'b1;
      lock_d_r <= 1'b0;
    end else begin
      idx_r <= idx_nxt;
      acc_r <= acc_nxt;
      golden_r <= golden_nxt;
      golden_vld_r <= golden_vld_nxt;
      cap_pend_r <= cap_pend_nxt;
      lock_d_r <= mgmt_lockout;
    end
  end

  // status, monitors and register group
  logic [15:0] stat_r, stat_nxt, rdata_nxt;
  logic strap_done_r;
  ufm_pkg::ufm_lock_t lk_r, lk_nxt;
  logic [7:0] cnt_r, cnt_nxt;
  logic loss_r, loss_nxt, locked_nxt, out_win;
  logic [9:0] temp_r, temp_nxt, delta;
  logic prev_vld_r, prev_vld_nxt, jump_r, jump_nxt;
  logic [17:0] lhs, rhs;
  logic [4:0] grp_a, grp_b;
  logic pcs_irq_nxt, cfg_irq_nxt, ev_irq_nxt, rec_nxt;

  assign restore = sum_ev && self_rec;
  assign out_win = pll_phase_err > cfg_val[0][ufm_pkg::PLL_WIN_LSB +: 3];
  assign delta = (temp_code > temp_r) ? temp_code - temp_r
                                      : temp_r - temp_code;
  assign lhs = 18'(delta * ufm_pkg::PCT_SCALE);
  assign rhs = 18'(cfg_val[1][ufm_pkg::THR_LSB +: 8] * temp_r);

  always_comb begin
    cfg_we = 3'h0;
    for (int i = 0; i < ufm_pkg::NUM_CFG; i++) begin
      cfg_wd[i] = CFG_DEF[i];
    end
    cfg_wd[2][ufm_pkg::PROT_STRAP_LSB +: 3] = strap_opts;
    if (restore || !strap_done_r) begin
      cfg_we = 3'h7;
    end else if (wr_ok) begin
      unique case (reg_addr)
        ufm_pkg::ADDR_PLL_CTL: begin
          cfg_we[0] = 1'b1;
          cfg_wd[0] = {4'h0, reg_wdata[11:0]};
        end
        ufm_pkg::ADDR_TEMP_B: begin
          cfg_we[1] = 1'b1;
          cfg_wd[1] = {8'h00, reg_wdata[7:0]};
        end
        ufm_pkg::ADDR_PROT: begin
          cfg_we[2] = 1'b1;
          cfg_wd[2] = {6'h00, reg_wdata[9:7],
            cfg_val[2][ufm_pkg::PROT_STRAP_LSB +: 3], 3'h0, reg_wdata[0]};
        end
        default: ;
      endcase
    end
  end

  always_comb begin
    stat_nxt = stat_r;
    loss_nxt = loss_r;
    jump_nxt = jump_r;
    if (wr_ok && reg_addr == ufm_pkg::ADDR_STATUS) begin
      stat_nxt[1:0] = reg_wdata[1:0];
      stat_nxt[15:2] = stat_r[15:2] & ~reg_wdata[15:2];
    end
    if (wr_ok && reg_addr == ufm_pkg::ADDR_PLL_CTL) begin
      loss_nxt = loss_r & ~reg_wdata[ufm_pkg::PLL_LOSS_BIT];
    end
    if (wr_ok && reg_addr == ufm_pkg::ADDR_TEMP_B) begin
      jump_nxt = jump_r & ~reg_wdata[ufm_pkg::TEMP_JUMP_BIT];
    end
    // sets follow clears so an event in the clear cycle survives
    stat_nxt[ufm_pkg::PCS_FLAG_LSB +: ufm_pkg::NUM_PCS] =
      stat_nxt[ufm_pkg::PCS_FLAG_LSB +: ufm_pkg::NUM_PCS] | pcs_bad_trans;
    stat_nxt[ufm_pkg::ST_CORR] = stat_nxt[ufm_pkg::ST_CORR] | (|cfg_corr);
    stat_nxt[ufm_pkg::ST_UNCORR] = stat_nxt[ufm_pkg::ST_UNCORR] | (|cfg_unc);
    stat_nxt[ufm_pkg::ST_SUM] = stat_nxt[ufm_pkg::ST_SUM] | sum_ev;
    stat_nxt[ufm_pkg::ST_RESTORE] = stat_nxt[ufm_pkg::ST_RESTORE] | restore;
    // lock detector
    lk_nxt = lk_r;
    cnt_nxt = cnt_r;
    locked_nxt = pll_locked;
    unique case (lk_r)
      ufm_pkg::UFM_LOCK: begin
        if (out_win) begin
          lk_nxt = ufm_pkg::UFM_WAIT;
          locked_nxt = 1'b0;
          loss_nxt = 1'b1;
          cnt_nxt = 8'h00;
        end
      end
      ufm_pkg::UFM_WAIT: begin
        if (out_win) begin
          cnt_nxt = 8'h00;
        end else if (pll_ref_tick) begin
          if (cnt_r + 8'h01 >= cfg_val[0][ufm_pkg::PLL_CNT_LSB +: 8]) begin
            lk_nxt = ufm_pkg::UFM_LOCK;
            locked_nxt = 1'b1;
          end else begin
            cnt_nxt = cnt_r + 8'h01;
          end
        end
      end
    endcase
    // thermal step check, first sample only primes the reference
    temp_nxt = temp_r;
    prev_vld_nxt = prev_vld_r;
    if (temp_valid) begin
      temp_nxt = temp_code;
      prev_vld_nxt = 1'b1;
      if (prev_vld_r && lhs > rhs) begin
        jump_nxt = 1'b1;
      end
    end
    grp_a = stat_nxt[6:2] & {5{~stat_nxt[0]}};
    grp_b = stat_nxt[11:7] & {5{~stat_nxt[1]}};
    pcs_irq_nxt = !(|grp_a || |grp_b);
    cfg_irq_nxt = !(|stat_nxt[15:12]);
    ev_irq_nxt = !(loss_nxt && !cfg_val[0][ufm_pkg::PLL_MASK_BIT]);
    rec_nxt = (|pcs_bad_trans) && self_rec;
    rdata_nxt = reg_rdata;
    if (reg_rd_en) begin
      unique case (reg_addr)
        ufm_pkg::ADDR_PLL_CTL: rdata_nxt = {loss_r, pll_locked, 2'h0,
          cfg_val[0][11:0]};
        ufm_pkg::ADDR_STATUS: rdata_nxt = stat_r;
        ufm_pkg::ADDR_TEMP_A: rdata_nxt = {6'h00, temp_r};
        ufm_pkg::ADDR_TEMP_B: rdata_nxt = {jump_r, 7'h00,
          cfg_val[1][7:0]};
        ufm_pkg::ADDR_PROT: rdata_nxt = {6'h00, cfg_val[2][9:4], 3'h0,
          cfg_val[2][0]};
        default: rdata_nxt = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      stat_r <= ufm_pkg::RST_STATUS;
      strap_done_r <= 1'b0;
      lk_r <= ufm_pkg::UFM_WAIT;
      cnt_r <= 8'h00;
      loss_r <= 1'b0;
      temp_r <= 10'h000;
      prev_vld_r <= 1'b0;
      jump_r <= 1'b0;
      reg_rdata <= 16'h0000;
      pcs_fault_irq_n <= 1'b1;
      cfg_upset_irq_n <= 1'b1;
      thermal_jump_irq_n <= 1'b1;
      upset_event_output_n <= 1'b1;
      pll_locked <= 1'b0;
      pcs_recover_rst <= 1'b0;
    end else begin
      stat_r <= stat_nxt;
      strap_done_r <= 1'b1;
      lk_r <= lk_nxt;
      cnt_r <= cnt_nxt;
      loss_r <= loss_nxt;
      temp_r <= temp_nxt;
      prev_vld_r <= prev_vld_nxt;
      jump_r <= jump_nxt;
      reg_rdata <= rdata_nxt;
      pcs_fault_irq_n <= pcs_irq_nxt;
      cfg_upset_irq_n <= cfg_irq_nxt;
      thermal_jump_irq_n <= !jump_nxt;
      upset_event_output_n <= ev_irq_nxt;
      pll_locked <= locked_nxt;
      pcs_recover_rst <= rec_nxt;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);

  sequence s_pcs_fault;
    pcs_bad_trans != 10'h000;
  endsequence
  sequence s_mismatch_rec;
    sum_ev && self_rec;
  endsequence

  chk_pcs_flag_set: assert property (s_pcs_fault |=>
    stat_r[11:2] != 10'h000)
    else $error("pcs fault not recorded");
  chk_pcs_recover_rst: assert property (s_pcs_fault |=>
    pcs_recover_rst == $past(self_rec))
    else $error("recovery reset wrong");
  chk_pcs_mask_hold: assert property ((stat_r[1:0] == 2'h3) |->
    pcs_fault_irq_n)
    else $error("masked pcs fault reached pin");
  chk_ecc_status_irq: assert property ((cfg_corr != 3'h0) |=>
    stat_r[ufm_pkg::ST_CORR] && !cfg_upset_irq_n)
    else $error("ecc correction not reported");
  chk_ecc_off_quiet: assert property ((ecc_field == 3'h0) |->
    cfg_corr == 3'h0 && cfg_unc == 3'h0)
    else $error("ecc active while disabled");
  chk_sum_mismatch_irq: assert property (sum_ev |=>
    stat_r[ufm_pkg::ST_SUM] && !cfg_upset_irq_n)
    else $error("checksum mismatch not flagged");
  chk_golden_cleared: assert property ($fell(mgmt_lockout) |=>
    !golden_vld_r && golden_r == 16'h0000)
    else $error("golden sum kept after lockout");
  chk_restore_defaults: assert property (s_mismatch_rec |=>
    (cfg_raw[0] == ufm_pkg::RST_PLL_CTL) ##2 cap_pend_r)
    else $error("defaults not restored");
  chk_ecc_repair: assert property ((ecc_en && cfg_flip[2] &&
    cfg_we == 3'h0) ##1 (cfg_we == 3'h0 && cfg_flip == 3'h0) |=>
    cfg_raw[2] == $past(cfg_raw[2], 2))
    else $error("ecc did not repair upset");
  chk_lock_drop: assert property ((lk_r == ufm_pkg::UFM_LOCK && out_win)
    |=> !pll_locked && loss_r)
    else $error("lock not dropped at once");
endmodule : ufm_monitor

// >>> test/ufm_host_model.sv
// Purpose: fault handler model on the far side of the monitor
// Assumes: interrupt lines active low, recovery request active high
// Notes: only counts events; the bench judges the counts
`timescale 1ns/1ps
module ufm_host_model (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic pcs_fault_irq_n,
  input wire logic upset_event_output_n,
  input wire logic pcs_recover_rst,
  output int pcs_irq_cnt,
  output int pll_irq_cnt,
  output int recover_cnt
);
  logic pcs_q;
  logic pll_q;
  always @(posedge sys_clk) begin
    if (!rst_b) begin
      pcs_q <= 1'b1;
      pll_q <= 1'b1;
      pcs_irq_cnt <= 0;
      pll_irq_cnt <= 0;
      recover_cnt <= 0;
    end else begin
      pcs_q <= pcs_fault_irq_n;
      pll_q <= upset_event_output_n;
      // a held interrupt level counts once, at its falling edge
      if (pcs_q && !pcs_fault_irq_n) pcs_irq_cnt <= pcs_irq_cnt + 1;
      if (pll_q && !upset_event_output_n) pll_irq_cnt <= pll_irq_cnt + 1;
      if (pcs_recover_rst) recover_cnt <= recover_cnt + 1;
    end
  end
endmodule : ufm_host_model

// >>> test/ufm_monitor_bench.sv
// Purpose: self-checking bench of the upset fault monitor
// Assumes: strobes one cycle wide, inputs moved on the falling edge
// Notes: straps held at 3'b101 so their latch shows in the protect word
`timescale 1ns/1ps
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin \
  err_total++; $display("[ERR] t=%0t got %h exp %h", $time, g, e); end end
module ufm_monitor_bench;
  logic sys_clk, rst_b, reg_wr_en, reg_rd_en, mgmt_lockout;
  logic temp_valid, pll_ref_tick, pcs_fault_irq_n, cfg_upset_irq_n;
  logic thermal_jump_irq_n, upset_event_output_n, pll_locked;
  logic pcs_recover_rst;
  logic [15:0] reg_addr, reg_wdata, reg_rdata, rv;
  logic [9:0] pcs_bad_trans, temp_code;
  logic [2:0] cfg_flip, strap_opts, pll_phase_err;
  int err_total, checks_done, pcs_irq_cnt, pll_irq_cnt, recover_cnt;

  ufm_monitor dut_u (.sys_clk(sys_clk), .rst_b(rst_b),
    .reg_addr(reg_addr), .reg_wr_en(reg_wr_en), .reg_wdata(reg_wdata),
    .reg_rd_en(reg_rd_en), .reg_rdata(reg_rdata),
    .mgmt_lockout(mgmt_lockout), .pcs_bad_trans(pcs_bad_trans),
    .cfg_flip(cfg_flip), .strap_opts(strap_opts), .temp_code(temp_code),
    .temp_valid(temp_valid), .pll_phase_err(pll_phase_err),
    .pll_ref_tick(pll_ref_tick), .pcs_fault_irq_n(pcs_fault_irq_n),
    .cfg_upset_irq_n(cfg_upset_irq_n),
    .thermal_jump_irq_n(thermal_jump_irq_n),
    .upset_event_output_n(upset_event_output_n),
    .pll_locked(pll_locked), .pcs_recover_rst(pcs_recover_rst));

  ufm_host_model host_u (.sys_clk(sys_clk), .rst_b(rst_b),
    .pcs_fault_irq_n(pcs_fault_irq_n),
    .upset_event_output_n(upset_event_output_n),
    .pcs_recover_rst(pcs_recover_rst), .pcs_irq_cnt(pcs_irq_cnt),
    .pll_irq_cnt(pll_irq_cnt), .recover_cnt(recover_cnt));

  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  task automatic finish_test();
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : finish_test

  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    @(negedge sys_clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr_en = 1'b1;
    @(negedge sys_clk);
    reg_wr_en = 1'b0;
  endtask : wr

  task automatic rchk(input logic [15:0] a, input logic [15:0] m,
                      input logic [15:0] e);
    @(negedge sys_clk);
    reg_addr = a;
    reg_rd_en = 1'b1;
    @(negedge sys_clk);
    reg_rd_en = 1'b0;
    rv = reg_rdata & m;
    `CHK(rv, e)
  endtask : rchk

  function automatic logic pick(input int s);
    case (s)
      0: pick = pcs_fault_irq_n;
      1: pick = cfg_upset_irq_n;
      2: pick = upset_event_output_n;
      default: pick = pll_locked;
    endcase
  endfunction : pick

  // bounded wait; running out counts a mismatch and ends the run
  task automatic wt(input int s, input logic lvl, input int lim);
    int n;
    n = 0;
    while (pick(s) !== lvl && n < lim) begin
      @(negedge sys_clk);
      n++;
    end
    if (pick(s) !== lvl) begin
      err_total++;
      $display("[ERR] t=%0t got %h exp %h", $time, pick(s), lvl);
      finish_test();
    end
  endtask : wt

  task automatic strobe(input logic [9:0] v);
    @(negedge sys_clk);
    pcs_bad_trans = v;
    @(negedge sys_clk);
    pcs_bad_trans = 10'h000;
  endtask : strobe

  task automatic flip(input logic [2:0] v);
    @(negedge sys_clk);
    cfg_flip = v;
    @(negedge sys_clk);
    cfg_flip = 3'h0;
  endtask : flip

  task automatic tsamp(input logic [9:0] c);
    @(negedge sys_clk);
    temp_code = c;
    temp_valid = 1'b1;
    @(negedge sys_clk);
    temp_valid = 1'b0;
  endtask : tsamp

  task automatic ticks(input int n);
    repeat (n) begin
      @(negedge sys_clk);
      pll_ref_tick = 1'b1;
      @(negedge sys_clk);
      pll_ref_tick = 1'b0;
    end
  endtask : ticks

  initial begin
    rst_b = 1'b0;
    {reg_wr_en, reg_rd_en, mgmt_lockout, temp_valid, pll_ref_tick} = 5'h00;
    reg_addr = 16'h0000;
    reg_wdata = 16'h0000;
    pcs_bad_trans = 10'h000;
    temp_code = 10'h000;
    cfg_flip = 3'h0;
    pll_phase_err = 3'h0;
    strap_opts = 3'h5;
    err_total = 0;
    checks_done = 0;
    repeat (2) @(negedge sys_clk);
    rst_b = 1'b1;
    repeat (2) @(negedge sys_clk);
    rchk(16'h01d7, 16'hffff, 16'h0a10);
    rchk(16'h01d8, 16'hffff, 16'h0000);
    rchk(16'h01ea, 16'hffff, 16'h000a);
    rchk(16'h01ee, 16'hffff, 16'h03d0);
    rchk(16'h01d9, 16'hffff, 16'h0000);
    strobe(10'h001);
    `CHK(pcs_fault_irq_n, 1'b0)
    rchk(16'h01d8, 16'hffff, 16'h0004);
    wr(16'h01d8, 16'h0004);
    `CHK(pcs_fault_irq_n, 1'b1)
    // each mask bit against a machine of its own half
    for (int k = 0; k < 2; k++) begin
      wr(16'h01d8, 16'h0001 << k);
      strobe(k == 0 ? 10'h001 : 10'h200);
      `CHK(pcs_fault_irq_n, 1'b1)
      rchk(16'h01d8, 16'hffff, (16'h0004 << (9 * k)) | (16'h0001 << k));
      wr(16'h01d8, 16'h0004 << (9 * k));
    end
    wr(16'h01ee, 16'h0381);
    strobe(10'h200);
    `CHK(pcs_fault_irq_n, 1'b0)
    rchk(16'h01d8, 16'hffff, 16'h0800);
    `CHK(recover_cnt, 1)
    wr(16'h01d8, 16'h0800);
    wr(16'h01ee, 16'h0380);
    `CHK(pcs_irq_cnt, 2)
    tsamp(10'h064);
    tsamp(10'h069);
    `CHK(thermal_jump_irq_n, 1'b1)
    tsamp(10'h078);
    `CHK(thermal_jump_irq_n, 1'b0)
    rchk(16'h01e8, 16'hffff, 16'h0078);
    rchk(16'h01ea, 16'hffff, 16'h800a);
    wr(16'h01ea, 16'h800a);
    `CHK(thermal_jump_irq_n, 1'b1)
    wr(16'h01d7, 16'h0204);
    ticks(3);
    repeat (2) @(negedge sys_clk);
    `CHK(pll_locked, 1'b0)
    ticks(1);
    wt(3, 1'b1, 3);
    @(negedge sys_clk);
    pll_phase_err = 3'h3;
    wt(3, 1'b0, 3);
    `CHK(upset_event_output_n, 1'b0)
    rchk(16'h01d7, 16'hffff, 16'h8204);
    pll_phase_err = 3'h0;
    wr(16'h01d7, 16'h8204);
    `CHK(upset_event_output_n, 1'b1)
    `CHK(pll_irq_cnt, 1)
    flip(3'h4);
    wt(1, 1'b0, 3);
    rchk(16'h01d8, 16'h3000, 16'h1000);
    wr(16'h01d8, 16'h1000);
    `CHK(cfg_upset_irq_n, 1'b1)
    wr(16'h01ee, 16'h0000);
    mgmt_lockout = 1'b1;
    repeat (8) @(negedge sys_clk);
    flip(3'h1);
    wt(1, 1'b0, 10);
    rchk(16'h01d8, 16'h4000, 16'h4000);
    // clearing is refused while locked out
    wr(16'h01d8, 16'h4000);
    rchk(16'h01d8, 16'h4000, 16'h4000);
    mgmt_lockout = 1'b0;
    repeat (8) @(negedge sys_clk);
    wr(16'h01d8, 16'h4000);
    repeat (8) @(negedge sys_clk);
    rchk(16'h01d8, 16'h4000, 16'h0000);
    `CHK(cfg_upset_irq_n, 1'b1)
    wr(16'h01ee, 16'h0001);
    mgmt_lockout = 1'b1;
    repeat (8) @(negedge sys_clk);
    flip(3'h2);
    wt(1, 1'b0, 10);
    repeat (2) @(negedge sys_clk);
    rchk(16'h01ee, 16'hffff, 16'h03d0);
    rchk(16'h01d7, 16'h0fff, 16'h0a10);
    rchk(16'h01d8, 16'hc000, 16'hc000);
    mgmt_lockout = 1'b0;
    finish_test();
  end
endmodule : ufm_monitor_bench
